// >>> core/acc_pkg.sv
// Constants, register map and types for the converter control block
package acc_pkg;
  localparam logic [7:0] ADDR_CTRL_ONE = 8'h00;
  localparam logic [7:0] ADDR_CTRL_TWO = 8'h04;
  localparam logic [7:0] ADDR_RESULT = 8'h08;
  localparam logic [7:0] ADDR_COMPARE = 8'h0c;
  localparam logic [7:0] ADDR_CONFIG = 8'h10;
  localparam logic [7:0] ADDR_PIN_EN = 8'h14;
  localparam logic [7:0] ADDR_CLK_GATE = 8'h18;
  localparam int ADDR_W = 8;
  localparam int RES_W = 12;
  localparam int CH_W = 5;
  localparam int NUM_PINS = 10;
  // Field positions
  localparam int F_CONT = 5;
  localparam int F_IRQ_EN = 6;
  localparam int F_DONE = 7;
  localparam int F_CMP_GTE = 0;
  localparam int F_CMP_EN = 1;
  localparam int F_HW_TRIG = 2;
  localparam int F_ACTIVE = 7;
  localparam int F_MODE = 2;
  localparam int F_CLK_SEL = 0;
  // Channel codes
  localparam logic [4:0] CH_PIN_LAST = 5'h09;
  localparam logic [4:0] CH_REFL_LAST = 5'h16;
  localparam logic [4:0] CH_TEMP = 5'h1a;
  localparam logic [4:0] CH_BANDGAP = 5'h1b;
  localparam logic [4:0] CH_RSVD_HI = 5'h1c;
  localparam logic [4:0] CH_REFH = 5'h1d;
  localparam logic [4:0] CH_GND = 5'h1e;
  localparam logic [4:0] CH_OFF = 5'h1f;
  // Reset values
  localparam logic [4:0] RST_CH = 5'h1f;
  localparam logic RST_GATE = 1'b1;
  localparam int SETTLE_CYC = 4;
  // Shortest settle that outlasts the comparator synchroniser
  localparam int SYNC_SETTLE_MIN = 3;
  typedef enum logic [1:0] {CLK_BUS, CLK_BUS_DIV2, CLK_LOCAL_ASYNC, CLK_ALT} acc_clk_sel_t;
  typedef enum logic [1:0] {FMT_8, FMT_10, FMT_12, FMT_RSVD} acc_mode_t;
  typedef enum logic [2:0] {
    SRC_PIN, SRC_REFL, SRC_TEMP, SRC_BANDGAP, SRC_REFH, SRC_GND, SRC_RESERVED, SRC_OFF
  } acc_src_t;
endpackage : acc_pkg

// >>> core/acc_adc_ctrl.sv
// Converter control: channel decode, clock choice, triggers, SAR engine, AHB-Lite registers
// What this block does
// - Clock gate bit is set by reset; clearing it stops the converter logic.
// - Codes 0..9 route to pins with their enables; 10..22 to low reference.
// - Codes map to temperature, bandgap, high reference, ground and disabled.
// - Codes 23..25 and 28 are reserved; their result is unspecified.
// - Conversion clock is bus, bus/2, local asynchronous or alternate clock.
// - With hardware trigger selected, a counter match starts a conversion only while the engine is idle.
// - The counter trigger works whether or not its interrupt is enabled.
// - Counter trigger works in run, wait, low power and stop3 modes.
// - Each sample resolves to 12 bits by linear successive approximation.
// - Result is unsigned, right justified, in 12, 10 or 8 bit format.
// - Single and continuous modes; single conversion returns to idle.
// - Result compares to a value, less-than or greater-equal, may interrupt.
// - Done flag sets when a conversion finishes with compare off or true, and may raise an interrupt.
// - Five bit channel field addresses up to 28 analog inputs.
// - Converter keeps operating in wait and stop3 modes.
// - Writing control one aborts and restarts, unless channel is all ones or hardware trigger is selected.
// - Done flag clears on control one write or result read.
//
// The AHB-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
module acc_adc_ctrl #(
  parameter int SETTLE = acc_pkg::SETTLE_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [acc_pkg::ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic local_async_conv_clock,
  input wire logic alternate_conv_clock,
  input wire logic rtc_match_event,
  input wire logic cmp_above,
  output logic [acc_pkg::RES_W-1:0] dac_trial,
  output logic sample_active,
  output acc_pkg::acc_src_t analog_src,
  output logic [acc_pkg::NUM_PINS-1:0] pin_route,
  output logic module_clk_en,
  output logic conv_irq
);
  import acc_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_SETTLE, ST_STEP} acc_state_t;

  // Registers
  logic [CH_W-1:0] channel_select_q;
  logic cont_q;
  logic irq_en_q;
  logic done_q;
  logic cmp_gte_q;
  logic cmp_en_q;
  logic hw_trigger_select_q;
  logic [1:0] clk_sel_q;
  logic [1:0] mode_q;
  logic [RES_W-1:0] compare_q;
  logic [RES_W-1:0] result_q;
  logic [NUM_PINS-1:0] pin_analog_enable_q;
  logic gate_q;
  // Bus pipeline
  logic wr_pend_q;
  logic [ADDR_W-1:0] wr_addr_q;
  logic [31:0] hrdata_q;
  // Engine
  // A new trial reaches cmp_hi four edges later (three flops and the agree stage);
  // a settle below three would let a step judge the previous trial
  localparam int SETTLE_EFF = (SETTLE < SYNC_SETTLE_MIN) ? SYNC_SETTLE_MIN : SETTLE;
  localparam int SETTLE_W = $clog2(SETTLE_EFF + 1);
  acc_state_t state_q;
  logic [RES_W-1:0] sar_q;
  logic [RES_W-1:0] bit_q;
  logic [SETTLE_W-1:0] settle_q;
  logic div2_q;

  // Three-stage pin synchronisers: rtc match, comparator, two clocks
  localparam int NSYNC = 4;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] s1_q;
  logic [NSYNC-1:0] s2_q;
  logic [NSYNC-1:0] s3_q;
  logic [NSYNC-1:0] held_q;
  logic [NSYNC-1:0] held_prev_q;
  logic [NSYNC-1:0] rise;
  assign raw_in = {alternate_conv_clock, local_async_conv_clock, cmp_above, rtc_match_event};
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          s1_q[gi] <= 1'b0;
          s2_q[gi] <= 1'b0;
          s3_q[gi] <= 1'b0;
          held_q[gi] <= 1'b0;
          held_prev_q[gi] <= 1'b0;
        end else begin
          s1_q[gi] <= raw_in[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          // Level counts once second and third flops agree
          if (s2_q[gi] == s3_q[gi]) begin
            held_q[gi] <= s3_q[gi];
          end
          held_prev_q[gi] <= held_q[gi];
        end
      end
      assign rise[gi] = held_q[gi] & ~held_prev_q[gi];
    end
  endgenerate

  // One synced rising edge of the match level is one trigger
  wire rtc_trig = rise[0];
  wire cmp_hi = held_q[1];

  // Bus decode
  wire addr_ok = hsel & htrans[1] & hready;
  wire rd_take = addr_ok & ~hwrite;
  wire wr_take = addr_ok & hwrite;
  wire wr_ctrl_one = wr_pend_q & (wr_addr_q == ADDR_CTRL_ONE) & gate_q;
  wire wr_ctrl_two = wr_pend_q & (wr_addr_q == ADDR_CTRL_TWO) & gate_q;
  wire wr_compare = wr_pend_q & (wr_addr_q == ADDR_COMPARE) & gate_q;
  wire wr_config = wr_pend_q & (wr_addr_q == ADDR_CONFIG) & gate_q;
  wire wr_pin_en = wr_pend_q & (wr_addr_q == ADDR_PIN_EN) & gate_q;
  // Only the gate bit stays writable while the module is gated
  wire wr_gate = wr_pend_q & (wr_addr_q == ADDR_CLK_GATE);
  wire rd_result = rd_take & (haddr == ADDR_RESULT) & gate_q;
  wire [CH_W-1:0] new_ch = hwdata[CH_W-1:0];

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign module_clk_en = gate_q;

  // Conversion clock enable
  // Each tick is one hclk cycle wide; slow sources arrive as synced edges
  wire tick_bus = clk_sel_q == CLK_BUS;
  wire tick_div2 = (clk_sel_q == CLK_BUS_DIV2) & div2_q;
  wire tick_async = (clk_sel_q == CLK_LOCAL_ASYNC) & rise[2];
  wire tick_alt = (clk_sel_q == CLK_ALT) & rise[3];
  wire conv_tick = gate_q & (tick_bus | tick_div2 | tick_async | tick_alt);

  // Channel decode
  wire ch_is_pin = channel_select_q <= CH_PIN_LAST;
  wire ch_is_refl = (channel_select_q > CH_PIN_LAST) & (channel_select_q <= CH_REFL_LAST);
  wire ch_off = channel_select_q == CH_OFF;
  logic [NUM_PINS-1:0] pin_onehot;
  always_comb begin
    pin_onehot = '0;
    if (ch_is_pin) begin
      pin_onehot[channel_select_q[3:0]] = 1'b1;
    end
  end
  // Pin switch closes only while converting and only if enabled
  assign pin_route = pin_onehot & pin_analog_enable_q & {NUM_PINS{sample_active}};

  always_comb begin
    if (ch_is_pin) begin
      analog_src = SRC_PIN;
    end else if (ch_is_refl) begin
      analog_src = SRC_REFL;
    end else begin
      unique case (channel_select_q)
        CH_TEMP: analog_src = SRC_TEMP;
        CH_BANDGAP: analog_src = SRC_BANDGAP;
        CH_REFH: analog_src = SRC_REFH;
        CH_GND: analog_src = SRC_GND;
        CH_OFF: analog_src = SRC_OFF;
        default: analog_src = SRC_RESERVED;
      endcase
    end
  end

  // Start decisions
  wire sw_start = wr_ctrl_one & (new_ch != CH_OFF) & ~hw_trigger_select_q;
  // A match arriving mid-conversion is dropped, not queued
  // Trigger never looks at interrupt or power mode inputs
  wire hw_start = gate_q & hw_trigger_select_q & rtc_trig & ~ch_off
                  & (state_q == ST_IDLE);
  wire last_step = (state_q == ST_STEP) & conv_tick & bit_q[0];
  wire [RES_W-1:0] final_sar = cmp_hi ? sar_q : (sar_q & ~bit_q);

  // Result formatting, right justified
  logic [RES_W-1:0] fmt_res;
  always_comb begin
    unique case (mode_q)
      FMT_8: fmt_res = {4'h0, final_sar[RES_W-1 -: 8]};
      FMT_10: fmt_res = {2'h0, final_sar[RES_W-1 -: 10]};
      default: fmt_res = final_sar;
    endcase
  end
  wire cmp_true = cmp_gte_q ? (fmt_res >= compare_q) : (fmt_res < compare_q);
  wire done_set = last_step & (~cmp_en_q | cmp_true);
  wire again = cont_q & ~hw_trigger_select_q;
  // A write in trigger mode stops the conversion and waits for the next match
  wire wr_abort = wr_ctrl_one & ((new_ch == CH_OFF) | hw_trigger_select_q);
  wire abort_now = ~gate_q | wr_abort;
  wire start_now = sw_start | hw_start | (last_step & again);
  wire done_clr = wr_ctrl_one | rd_result;

  // Engine
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= ST_IDLE;
      sar_q <= '0;
      bit_q <= '0;
      settle_q <= '0;
      div2_q <= 1'b0;
    end else begin
      if (gate_q) begin
        div2_q <= ~div2_q;
      end
      if (abort_now) begin
        state_q <= ST_IDLE;
      end else if (start_now) begin
        state_q <= ST_SETTLE;
        bit_q <= {1'b1, {(RES_W-1){1'b0}}};
        sar_q <= {1'b1, {(RES_W-1){1'b0}}};
        settle_q <= SETTLE_W'(SETTLE_EFF);
      end else begin
        unique case (state_q)
          ST_IDLE: begin
          end
          ST_SETTLE: begin
            if (settle_q == '0) begin
              state_q <= ST_STEP;
            end else begin
              settle_q <= settle_q - 1'b1;
            end
          end
          ST_STEP: begin
            if (conv_tick) begin
              // Keep or drop the trial bit, then try the next one
              sar_q <= final_sar | (bit_q >> 1);
              bit_q <= bit_q >> 1;
              settle_q <= SETTLE_W'(SETTLE_EFF);
              state_q <= bit_q[0] ? ST_IDLE : ST_SETTLE;
            end
          end
          // Unused state code falls back to idle
          default: begin
            state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  assign sample_active = state_q != ST_IDLE;
  assign dac_trial = sar_q;
  assign conv_irq = done_q & irq_en_q;

  // Registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      channel_select_q <= RST_CH;
      cont_q <= 1'b0;
      irq_en_q <= 1'b0;
      done_q <= 1'b0;
      cmp_gte_q <= 1'b0;
      cmp_en_q <= 1'b0;
      hw_trigger_select_q <= 1'b0;
      clk_sel_q <= CLK_BUS;
      mode_q <= FMT_8;
      compare_q <= '0;
      result_q <= '0;
      pin_analog_enable_q <= '0;
      gate_q <= RST_GATE;
    end else begin
      if (wr_ctrl_one) begin
        channel_select_q <= new_ch;
        cont_q <= hwdata[F_CONT];
        irq_en_q <= hwdata[F_IRQ_EN];
      end
      if (wr_ctrl_two) begin
        cmp_gte_q <= hwdata[F_CMP_GTE];
        cmp_en_q <= hwdata[F_CMP_EN];
        hw_trigger_select_q <= hwdata[F_HW_TRIG];
      end
      if (wr_config) begin
        clk_sel_q <= hwdata[F_CLK_SEL +: 2];
        mode_q <= hwdata[F_MODE +: 2];
      end
      if (wr_compare) begin
        compare_q <= hwdata[RES_W-1:0];
      end
      if (wr_pin_en) begin
        pin_analog_enable_q <= hwdata[NUM_PINS-1:0];
      end
      if (wr_gate) begin
        gate_q <= hwdata[0];
      end
      // Result follows every finished conversion, compare or not
      if (last_step) begin
        result_q <= fmt_res;
      end
      // Set wins over either clear
      if (done_set) begin
        done_q <= 1'b1;
      end else if (done_clr) begin
        done_q <= 1'b0;
      end
    end
  end

  // Bus pipeline and read data
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    unique case (haddr)
      ADDR_CTRL_ONE: rd_mux = {24'h0, done_q, irq_en_q, cont_q, channel_select_q};
      ADDR_CTRL_TWO: rd_mux = {24'h0, sample_active, 4'h0, hw_trigger_select_q,
                               cmp_en_q, cmp_gte_q};
      ADDR_RESULT: rd_mux = {20'h0, result_q};
      ADDR_COMPARE: rd_mux = {20'h0, compare_q};
      ADDR_CONFIG: rd_mux = {28'h0, mode_q, clk_sel_q};
      ADDR_PIN_EN: rd_mux = {22'h0, pin_analog_enable_q};
      ADDR_CLK_GATE: rd_mux = {31'h0, gate_q};
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
      hrdata_q <= '0;
    end else begin
      wr_pend_q <= wr_take;
      if (addr_ok) begin
        wr_addr_q <= haddr;
      end
      if (rd_take) begin
        hrdata_q <= rd_mux;
      end
    end
  end

endmodule : acc_adc_ctrl

// >>> test/acc_adc_ctrl_properties.sv
// Port-level checks for the converter control block
`timescale 1ns/100ps
module acc_adc_ctrl_chk #(
  parameter int SETTLE = acc_pkg::SETTLE_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [acc_pkg::RES_W-1:0] dac_trial,
  input wire logic sample_active,
  input wire acc_pkg::acc_src_t analog_src,
  input wire logic [acc_pkg::NUM_PINS-1:0] pin_route,
  input wire logic module_clk_en,
  input wire logic conv_irq
);
  import acc_pkg::*;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_gate_reset: assert property ($rose(hresetn) |-> module_clk_en)
    else $error("clock gate not set after reset");
  chk_gate_stop: assert property (!module_clk_en |=> !sample_active)
    else $error("conversion runs with gate cleared");
  chk_gate_frozen: assert property (!module_clk_en [*2] |-> $stable(dac_trial))
    else $error("trial moves with gate cleared");
  chk_route_src: assert property (pin_route != 10'h000 |->
    analog_src == SRC_PIN && sample_active && $onehot(pin_route))
    else $error("pin switch closed wrongly");
  chk_off_idle: assert property (analog_src == SRC_OFF [*2] |-> !sample_active)
    else $error("busy while disabled");
  chk_first_trial: assert property ($rose(sample_active) |-> dac_trial == 12'h800)
    else $error("first trial is not midscale");
  chk_trial_live: assert property (sample_active |-> dac_trial != 12'h000)
    else $error("trial word empty while busy");
  chk_irq_cause: assert property ($rose(conv_irq) |-> $past(sample_active))
    else $error("done without a conversion");
  cover property ($rose(conv_irq));
  cover property (pin_route != 10'h000);
  cover property (!module_clk_en);
endmodule : acc_adc_ctrl_chk

// >>> test/acc_analog_model.sv
// Analog side: selected source level compared with the trial word
`timescale 1ns/100ps
module acc_analog_model (
  input wire logic [11:0] pin_level,
  input wire logic [11:0] dac_trial,
  input wire acc_pkg::acc_src_t analog_src,
  input wire logic [9:0] pin_route,
  output logic cmp_above
);
  import acc_pkg::*;
  logic [11:0] level;
  assign level = (analog_src == SRC_REFH) ? 12'hfff :
    (analog_src == SRC_PIN && pin_route != 10'h000) ? pin_level : 12'h000;
  assign cmp_above = level >= dac_trial;
endmodule : acc_analog_model

// >>> test/acc_adc_ctrl_bench.sv
// Self-checking bench for the converter control block
`timescale 1ns/100ps
module acc_adc_ctrl_bench;
  import acc_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, lclk, aclk, rtc, hreadyout, hresp, cmp_above;
  logic sample_active, module_clk_en, conv_irq;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rdv;
  logic [11:0] dac_trial, pin_level;
  logic [9:0] pin_route;
  acc_src_t analog_src;
  int miscompares, compares;
  assign hready = hreadyout;
  acc_adc_ctrl #(.SETTLE(2)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .local_async_conv_clock(lclk), .alternate_conv_clock(aclk), .rtc_match_event(rtc),
    .cmp_above(cmp_above), .dac_trial(dac_trial), .sample_active(sample_active),
    .analog_src(analog_src), .pin_route(pin_route), .module_clk_en(module_clk_en),
    .conv_irq(conv_irq));
  acc_analog_model far (.pin_level(pin_level), .dac_trial(dac_trial),
    .analog_src(analog_src), .pin_route(pin_route), .cmp_above(cmp_above));
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  initial begin
    lclk = 1'b0;
    forever #7 lclk <= ~lclk;
  end
  initial begin
    aclk = 1'b0;
    forever #9 aclk <= ~aclk;
  end
  task automatic conclude();
    if (miscompares == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude
  task automatic ck(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask : ck
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdv = hrdata;
  endtask : bus
  task automatic wait_irq();
    int n;
    n = 0;
    while (conv_irq !== 1'b1 && n < 3000) begin
      @(negedge hclk);
      n++;
    end
  endtask : wait_irq
  task automatic conv(input logic [31:0] cfg, input logic [4:0] ch, input logic [31:0] exp);
    bus(1'b1, ADDR_CONFIG, cfg);
    bus(1'b1, ADDR_CTRL_ONE, 32'h40 | ch);
    wait_irq();
    ck(conv_irq, 1'b1);
    bus(1'b0, ADDR_RESULT, 0);
    ck(rdv, exp);
    @(negedge hclk);
    ck(conv_irq, 1'b0);
  endtask : conv
  function automatic acc_src_t src_of(input int c);
    case (c) inside
      [0:9]: return SRC_PIN;
      [10:22]: return SRC_REFL;
      26: return SRC_TEMP;
      27: return SRC_BANDGAP;
      29: return SRC_REFH;
      30: return SRC_GND;
      31: return SRC_OFF;
      default: return SRC_RESERVED;
    endcase
  endfunction : src_of
  initial begin
    repeat (40000) @(posedge hclk);
    miscompares++;
    conclude();
  end
  initial begin
    hresetn = 1'b0;
    hsel = 1'b1;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    rtc = 1'b0;
    pin_level = 12'ha5c;
    miscompares = 0;
    compares = 0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, ADDR_CLK_GATE, 0);
    ck(rdv, 1);
    bus(1'b0, ADDR_CTRL_ONE, 0);
    ck(rdv, 32'h1f);
    bus(1'b0, 8'h1c, 0);
    ck(rdv, 0);
    bus(1'b1, ADDR_PIN_EN, 32'h3ff);
    for (int c = 0; c < 32; c++) begin
      // Each code but all ones starts a conversion that the next write aborts before it completes
      bus(1'b1, ADDR_CTRL_ONE, c);
      repeat (2) @(negedge hclk);
      ck(32'(analog_src), 32'(src_of(c)));
      ck(32'(pin_route), (c < 10) ? 32'(1 << c) : 0);
      ck(32'(sample_active), 32'(c != 31));
    end
    for (int i = 0; i < 4; i++) begin
      conv({28'h0, 2'(i % 3), 2'(i)}, 5'h00, pin_level >> (4 - 2 * (i % 3)));
    end
    conv(32'h8, CH_REFH, 32'hfff);
    bus(1'b1, ADDR_COMPARE, pin_level);
    bus(1'b1, ADDR_CTRL_TWO, 32'h3);
    conv(32'h8, 5'h00, pin_level);
    bus(1'b1, ADDR_CTRL_TWO, 32'h2);
    bus(1'b1, ADDR_CTRL_ONE, 32'h40);
    wait_irq();
    ck(conv_irq, 1'b0);
    bus(1'b0, ADDR_RESULT, 0);
    ck(rdv, pin_level);
    bus(1'b1, ADDR_CTRL_TWO, 32'h4);
    bus(1'b1, ADDR_CTRL_ONE, 32'h40);
    repeat (20) @(negedge hclk);
    ck(sample_active, 1'b0);
    @(posedge hclk);
    rtc <= 1'b1;
    wait_irq();
    ck(conv_irq, 1'b1);
    bus(1'b0, ADDR_RESULT, 0);
    ck(rdv, pin_level);
    repeat (100) @(negedge hclk);
    ck(sample_active, 1'b0);
    @(posedge hclk);
    rtc <= 1'b0;
    bus(1'b1, ADDR_CTRL_TWO, 0);
    bus(1'b1, ADDR_CTRL_ONE, 32'h60);
    wait_irq();
    bus(1'b0, ADDR_RESULT, 0);
    ck(rdv, pin_level);
    ck(sample_active, 1'b1);
    bus(1'b1, ADDR_CTRL_ONE, 32'h1f);
    @(negedge hclk);
    ck(sample_active, 1'b0);
    bus(1'b1, ADDR_CLK_GATE, 0);
    bus(1'b1, ADDR_CTRL_ONE, 32'h40);
    repeat (3) @(negedge hclk);
    ck(module_clk_en, 1'b0);
    ck(sample_active, 1'b0);
    bus(1'b1, ADDR_CLK_GATE, 1);
    conclude();
  end
endmodule : acc_adc_ctrl_bench
bind acc_adc_ctrl acc_adc_ctrl_chk #(.SETTLE(SETTLE)) u_chk (.hclk(hclk), .hresetn(hresetn),
  .dac_trial(dac_trial), .sample_active(sample_active), .analog_src(analog_src),
  .pin_route(pin_route), .module_clk_en(module_clk_en), .conv_irq(conv_irq));
